// File: src/acr_pkg.sv
package acr_pkg;

  // ------------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_CSR = 10'h070;
  localparam logic [IDX_W-1:0] IDX_RES_HI = 10'h071;
  localparam logic [IDX_W-1:0] IDX_RES_LO = 10'h072;
  localparam logic [IDX_W-1:0] IDX_INT_STATUS = 10'h073;
  localparam logic [IDX_W-1:0] IDX_INT_CLEAR = 10'h074;
  localparam logic [IDX_W-1:0] IDX_INT_ENABLE = 10'h075;

  // ------------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------------
  localparam int unsigned CH_W = 4;
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned RES_HI_LSB = 2;
  localparam int unsigned RES_LO_W = 2;
  localparam int unsigned INT_W = 2;
  localparam int unsigned INT_DONE = 0;
  localparam int unsigned INT_OVERRUN = 1;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
  localparam logic [INT_W-1:0] INT_RESET = 2'h0;

  // ------------------------------------------------------------------
  // Converter timing: divides in pclk cycles, lengths in converter-clock ticks
  // ------------------------------------------------------------------
  localparam int unsigned DIV_SLOW = 4;
  localparam int unsigned DIV_FAST = 2;
  localparam logic [1:0] DIV_SLOW_LAST = 2'(DIV_SLOW - 1);
  localparam logic [1:0] DIV_FAST_LAST = 2'(DIV_FAST - 1);
  // Three ticks a step so the comparator sync path settles even at the fast divide
  localparam int unsigned SAMPLE_TICKS = 4;
  localparam int unsigned STEP_TICKS = 3;
  localparam int unsigned CONV_TICKS = SAMPLE_TICKS + STEP_TICKS * RESULT_W;
  localparam logic [2:0] SAMPLE_LAST = 3'(SAMPLE_TICKS - 1);
  localparam logic [2:0] STEP_LAST = 3'(STEP_TICKS - 1);
  localparam logic [3:0] MSB_IDX = 4'(RESULT_W - 1);

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic eoc;
    logic speed;
    logic conv_on;
    logic rsvd;
    logic [CH_W-1:0] channel;
  } acr_csr_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } acr_apb_req_t;

  typedef struct packed {
    logic mux_en;
    logic [CH_W-1:0] channel;
    logic sample;
    logic [RESULT_W-1:0] trial;
  } acr_ana_ctrl_t;

  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_STEP} acr_sar_state_t;

  function automatic logic [RESULT_W-1:0] acr_bit_mask(input logic [3:0] idx);
    acr_bit_mask = 10'h001 << idx;
  endfunction

  function automatic logic acr_chan_reserved(input logic [CH_W-1:0] ch);
    acr_chan_reserved = (ch == 4'h6) || (ch == 4'h7) || (ch == 4'h9) || (ch == 4'hb);
  endfunction

endpackage

// File: src/acr_sar.sv
`timescale 1ns/1ns
module acr_sar
  import acr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic restart,
  input wire logic fast,
  input wire logic comparator_in,
  output logic sample_ff,
  output logic [RESULT_W-1:0] trial_ff,
  output logic done_ff,
  output logic [RESULT_W-1:0] code_ff,
  output logic busy
);

  acr_sar_state_t state_ff, nxt_state;
  logic [1:0] div_ff, nxt_div;
  logic [2:0] phase_ff, nxt_phase;
  logic [3:0] bit_ff, nxt_bit;
  logic nxt_sample, nxt_done;
  logic [RESULT_W-1:0] nxt_trial, nxt_code, keep;
  logic cmp_s1_ff, cmp_s2_ff, cmp_s3_ff, cmp_ff, nxt_cmp;
  logic tick;

  // ------------------------------------------------------------------
  // Clock divider and comparator synchroniser
  // ------------------------------------------------------------------
  always_comb begin
    tick = enable && (div_ff >= (fast ? DIV_FAST_LAST : DIV_SLOW_LAST));
    nxt_div = (!enable || tick) ? 2'h0 : 2'(div_ff + 2'h1);
    nxt_cmp = (cmp_s2_ff == cmp_s3_ff) ? cmp_s3_ff : cmp_ff;
  end

  // ------------------------------------------------------------------
  // Successive approximation sequence
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_bit = bit_ff;
    nxt_trial = trial_ff;
    nxt_sample = sample_ff;
    nxt_code = code_ff;
    nxt_done = 1'b0;
    keep = cmp_ff ? trial_ff : (trial_ff & ~acr_bit_mask(bit_ff));
    if (!enable) begin
      nxt_state = SAR_IDLE;
      nxt_phase = 3'h0;
      nxt_trial = '0;
      nxt_sample = 1'b0;
    end else if (restart || state_ff == SAR_IDLE) begin
      nxt_state = SAR_SAMPLE;
      nxt_phase = 3'h0;
      nxt_trial = '0;
      nxt_sample = 1'b1;
    end else if (tick) begin
      case (state_ff)
        SAR_SAMPLE: begin
          if (phase_ff == SAMPLE_LAST) begin
            nxt_state = SAR_STEP;
            nxt_phase = 3'h0;
            nxt_sample = 1'b0;
            nxt_bit = MSB_IDX;
            nxt_trial = acr_bit_mask(MSB_IDX);
          end else begin
            nxt_phase = 3'(phase_ff + 3'h1);
          end
        end
        SAR_STEP: begin
          if (phase_ff != STEP_LAST) begin
            nxt_phase = 3'(phase_ff + 3'h1);
          end else if (bit_ff == 4'h0) begin
            // Comparator stuck high or low walks the code to all ones or zeros
            nxt_code = keep;
            nxt_done = 1'b1;
            nxt_state = SAR_SAMPLE;
            nxt_phase = 3'h0;
            nxt_trial = '0;
            nxt_sample = 1'b1;
          end else begin
            nxt_trial = keep | acr_bit_mask(4'(bit_ff - 4'h1));
            nxt_bit = 4'(bit_ff - 4'h1);
            nxt_phase = 3'h0;
          end
        end
        default: nxt_state = SAR_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SAR_IDLE;
      div_ff <= 2'h0;
      phase_ff <= 3'h0;
      bit_ff <= 4'h0;
      trial_ff <= '0;
      sample_ff <= 1'b0;
      code_ff <= RESULT_RESET;
      done_ff <= 1'b0;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      cmp_s3_ff <= 1'b0;
      cmp_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      phase_ff <= nxt_phase;
      bit_ff <= nxt_bit;
      trial_ff <= nxt_trial;
      sample_ff <= nxt_sample;
      code_ff <= nxt_code;
      done_ff <= nxt_done;
      cmp_s1_ff <= comparator_in;
      cmp_s2_ff <= cmp_s1_ff;
      cmp_s3_ff <= cmp_s2_ff;
      cmp_ff <= nxt_cmp;
    end
  end

  assign busy = (state_ff != SAR_IDLE);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_slow_run;
    (tick && !fast) ##1 (enable && !fast)[*4];
  endsequence
  sequence s_fast_run;
    (tick && fast) ##1 (enable && fast)[*2];
  endsequence

  a_slow_divide: assert property (s_slow_run |-> tick) else $error("slow tick not every 4 clocks");
  a_fast_divide: assert property (s_fast_run |-> tick) else $error("fast tick not every 2 clocks");
  a_on_begins: assert property ($rose(enable) |=> ##1 (state_ff == SAR_SAMPLE && sample_ff))
    else $error("enable did not start sampling");
  a_cont_repeat: assert property (done_ff |-> (state_ff == SAR_SAMPLE && sample_ff))
    else $error("no automatic next conversion");
  a_restart_abort: assert property ((restart && enable) |=>
      (state_ff == SAR_SAMPLE && phase_ff == 3'h0 && !done_ff))
    else $error("restart did not abort");

endmodule // acr_sar

// File: src/acr_top.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
module acr_top
  import acr_pkg::*;
#(
  parameter int unsigned NUM_CHANNELS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire acr_apb_req_t apb_req,
  input wire logic comparator_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output acr_ana_ctrl_t ana_ctrl
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction

  function automatic logic chan_usable(input logic [CH_W-1:0] ch);
    chan_usable = !acr_chan_reserved(ch) && (32'(ch) < NUM_CHANNELS);
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  acr_csr_t csr_ff, nxt_csr, wdata_csr;
  logic [RESULT_W-1:0] result_ff, nxt_result;
  logic [INT_W-1:0] int_status_ff, nxt_int_status;
  logic [INT_W-1:0] int_enable_ff, nxt_int_enable;
  logic [INT_W-1:0] int_events, int_clear;
  logic irq_ff, nxt_irq;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic restart_ff, nxt_restart;
  logic [CH_W-1:0] chan_ff, nxt_chan;
  logic mux_en_ff, nxt_mux_en;

  logic access, xfer_done, mapped;
  logic sel_csr, sel_hi, sel_lo, sel_status, sel_clear, sel_enable;
  logic wr_csr, rd_hi, wr_clear, wr_enable, eoc_clear;

  logic sar_sample, sar_done, sar_busy;
  logic [RESULT_W-1:0] sar_trial, sar_code;

  // ------------------------------------------------------------------
  // Converter sequencer
  // ------------------------------------------------------------------
  acr_sar u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .enable(csr_ff.conv_on),
    .restart(restart_ff),
    .fast(csr_ff.speed),
    .comparator_in(comparator_in),
    .sample_ff(sar_sample),
    .trial_ff(sar_trial),
    .done_ff(sar_done),
    .code_ff(sar_code),
    .busy(sar_busy)
  );

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  always_comb begin
    access = apb_req.psel && apb_req.penable;
    // Access phase is two cycles: answer is prepared, then pready rises
    xfer_done = access && pready_ff;
    sel_csr = hit(apb_req.paddr, IDX_CSR);
    sel_hi = hit(apb_req.paddr, IDX_RES_HI);
    sel_lo = hit(apb_req.paddr, IDX_RES_LO);
    sel_status = hit(apb_req.paddr, IDX_INT_STATUS);
    sel_clear = hit(apb_req.paddr, IDX_INT_CLEAR);
    sel_enable = hit(apb_req.paddr, IDX_INT_ENABLE);
    mapped = sel_csr || sel_hi || sel_lo || sel_status || sel_clear || sel_enable;
    wr_csr = xfer_done && apb_req.pwrite && sel_csr;
    rd_hi = xfer_done && !apb_req.pwrite && sel_hi;
    wr_clear = xfer_done && apb_req.pwrite && sel_clear;
    wr_enable = xfer_done && apb_req.pwrite && sel_enable;
    wdata_csr = acr_csr_t'(apb_req.pwdata[7:0]);
  end

  always_comb begin
    nxt_pready = access && !pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0;
    if (access && !pready_ff) begin
      if (!mapped) begin
        nxt_pslverr = 1'b1;
      end else if (!apb_req.pwrite) begin
        if (sel_csr) begin
          nxt_prdata = 32'(csr_ff);
        end else if (sel_hi) begin
          nxt_prdata = 32'(result_ff[RESULT_W-1:RES_HI_LSB]);
        end else if (sel_lo) begin
          nxt_prdata = 32'(result_ff[RES_LO_W-1:0]);
        end else if (sel_status) begin
          nxt_prdata = 32'(int_status_ff);
        end else if (sel_enable) begin
          nxt_prdata = 32'(int_enable_ff);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // ------------------------------------------------------------------
  // Control/status and result registers
  // ------------------------------------------------------------------
  always_comb begin
    nxt_csr = csr_ff;
    nxt_restart = 1'b0;
    eoc_clear = wr_csr || rd_hi;
    if (wr_csr) begin
      nxt_csr.speed = wdata_csr.speed;
      nxt_csr.conv_on = wdata_csr.conv_on;
      nxt_csr.channel = wdata_csr.channel;
      nxt_restart = wdata_csr.conv_on && csr_ff.conv_on && (wdata_csr.channel != csr_ff.channel);
    end
    // Written value of the reserved bit is dropped so it always reads zero
    nxt_csr.rsvd = 1'b0;
    if (sar_done) begin
      nxt_csr.eoc = 1'b1;
    end else if (eoc_clear) begin
      nxt_csr.eoc = 1'b0;
    end
    // Not double buffered: a fresh completion overwrites both halves
    nxt_result = sar_done ? sar_code : result_ff;
    nxt_chan = nxt_csr.channel;
    nxt_mux_en = nxt_csr.conv_on && chan_usable(nxt_csr.channel);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_ff <= acr_csr_t'(CSR_RESET);
      result_ff <= RESULT_RESET;
      restart_ff <= 1'b0;
      chan_ff <= '0;
      mux_en_ff <= 1'b0;
    end else begin
      csr_ff <= nxt_csr;
      result_ff <= nxt_result;
      restart_ff <= nxt_restart;
      chan_ff <= nxt_chan;
      mux_en_ff <= nxt_mux_en;
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  always_comb begin
    int_events = '0;
    int_events[INT_DONE] = sar_done;
    // Overrun: a result lands while the previous one was never collected
    int_events[INT_OVERRUN] = sar_done && csr_ff.eoc && !eoc_clear;
    int_clear = wr_clear ? apb_req.pwdata[INT_W-1:0] : '0;
    nxt_int_status = (int_status_ff & ~int_clear) | int_events;
    nxt_int_enable = wr_enable ? apb_req.pwdata[INT_W-1:0] : int_enable_ff;
    nxt_irq = |(nxt_int_status & nxt_int_enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_ff <= INT_RESET;
      int_enable_ff <= INT_RESET;
      irq_ff <= 1'b0;
    end else begin
      int_status_ff <= nxt_int_status;
      int_enable_ff <= nxt_int_enable;
      irq_ff <= nxt_irq;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign ana_ctrl.mux_en = mux_en_ff;
  assign ana_ctrl.channel = chan_ff;
  assign ana_ctrl.sample = sar_sample;
  assign ana_ctrl.trial = sar_trial;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic [RESULT_W-RES_HI_LSB-1:0] res_hi;
  logic [RES_LO_W-1:0] res_lo;
  logic [7:0] csr_bits;
  assign res_hi = result_ff[RESULT_W-1:RES_HI_LSB];
  assign res_lo = result_ff[RES_LO_W-1:0];
  assign csr_bits = csr_ff;
  acr_csr_t rd_csr;
  assign rd_csr = acr_csr_t'(prdata_ff[7:0]);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_first_access;
    access && !pready_ff && !apb_req.pwrite && mapped;
  endsequence
  sequence s_read_hi;
    (s_first_access and sel_hi) ##1 pready_ff;
  endsequence
  sequence s_read_lo;
    (s_first_access and sel_lo) ##1 pready_ff;
  endsequence
  sequence s_read_csr;
    (s_first_access and sel_csr) ##1 pready_ff;
  endsequence

  a_done_sets_eoc: assert property (sar_done |=> csr_ff.eoc)
    else $error("completion did not set done flag");
  a_eoc_only_hw: assert property ($rose(csr_ff.eoc) |-> $past(sar_done))
    else $error("done flag rose without a completion");
  a_hi_read_clears: assert property ((rd_hi && !sar_done) |=> !csr_ff.eoc)
    else $error("high read left done flag set");
  a_csr_write_clears: assert property ((wr_csr && !sar_done) |=> !csr_ff.eoc)
    else $error("control write left done flag set");
  a_csr_write_takes: assert property (wr_csr |=> (csr_ff.channel == $past(wdata_csr.channel)
      && csr_ff.speed == $past(wdata_csr.speed) && csr_ff.conv_on == $past(wdata_csr.conv_on)))
    else $error("control write not stored");
  a_rsvd_reads_zero: assert property (s_read_csr |-> (prdata_ff[31:8] == 24'h0 && !rd_csr.rsvd
      && prdata_ff[7:0] == $past(csr_bits)))
    else $error("control read wrong or reserved bit set");
  a_hi_read_value: assert property (s_read_hi |-> prdata_ff == 32'($past(res_hi)))
    else $error("high result read mismatch");
  a_lo_read_value: assert property (s_read_lo |-> (prdata_ff[31:RES_LO_W] == 30'h0
      && prdata_ff[RES_LO_W-1:0] == $past(res_lo)))
    else $error("low result read mismatch");
  a_unmapped_error: assert property ((access && !pready_ff && !mapped) |=> (pready_ff && pslverr_ff))
    else $error("unmapped access not refused");
  a_one_wait: assert property ((access && !pready_ff) |=> pready_ff ##1 !pready_ff)
    else $error("answer not after one wait cycle");
  a_off_stops: assert property (!csr_ff.conv_on |=> (!sar_busy && !sar_sample && sar_trial == '0))
    else $error("converter active while off");
  a_chan_abort: assert property ((wr_csr && nxt_restart) |=> ##1 (sar_sample && !sar_done))
    else $error("channel change did not restart");
  a_mux_legal: assert property (mux_en_ff |-> (chan_usable(chan_ff) && csr_ff.conv_on))
    else $error("reserved or absent channel routed");
  a_irq_level: assert property (irq_ff == |(int_status_ff & int_enable_ff))
    else $error("interrupt level mismatch");

  // ------------------------------------------------------------------
  // Holding checks
  // ------------------------------------------------------------------
  // Flag and result move only on a completion or a clear, never on a stray access
  a_eoc_holds: assert property ((!sar_done && !eoc_clear) |=> $stable(csr_ff.eoc))
    else $error("done flag moved without cause");
  a_result_holds: assert property (!sar_done |=> $stable(result_ff))
    else $error("result changed without a completion");
  a_result_capture: assert property (sar_done |=> result_ff == $past(sar_code))
    else $error("completed code not stored");
  a_no_stray_write: assert property (!wr_csr |=> ($stable(csr_ff.speed) && $stable(csr_ff.conv_on)
      && $stable(csr_ff.channel)))
    else $error("control bits changed without a write");
  a_rsvd_stays_zero: assert property (!csr_ff.rsvd)
    else $error("reserved bit stored as one");
  a_same_chan_keeps: assert property ((wr_csr && wdata_csr.channel == csr_ff.channel) |=> !restart_ff)
    else $error("restart without a channel change");
  a_restart_pulse: assert property (restart_ff |=> !restart_ff)
    else $error("restart longer than one cycle");
  a_mux_follows: assert property ((mux_en_ff == (csr_ff.conv_on && chan_usable(csr_ff.channel)))
      && chan_ff == csr_ff.channel)
    else $error("input routing does not follow control");

  // ------------------------------------------------------------------
  // Interrupt checks
  // ------------------------------------------------------------------
  // Overrun is the only sign that a result was lost, since the registers are not latched
  a_done_status: assert property (sar_done |=> int_status_ff[INT_DONE])
    else $error("completion not recorded in status");
  a_overrun_flag: assert property ((sar_done && csr_ff.eoc && !eoc_clear) |=> int_status_ff[INT_OVERRUN])
    else $error("lost result not flagged");
  a_enable_write: assert property (wr_enable |=> int_enable_ff == $past(apb_req.pwdata[INT_W-1:0]))
    else $error("interrupt enable write not stored");
  a_clear_write: assert property ((wr_clear && !sar_done) |=> (int_status_ff & $past(int_clear)) == '0)
    else $error("status bits not cleared");

  // ------------------------------------------------------------------
  // Bus answer checks
  // ------------------------------------------------------------------
  // Idle read data stays zero so a late sample never picks up a stale word
  a_error_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("error reported without ready");
  a_idle_data_zero: assert property (!pready_ff |-> prdata_ff == 32'h0)
    else $error("read data outside the answer cycle");

endmodule // acr_top

// File: verif/acr_ana_model.sv
`timescale 1ns/1ns
module acr_ana_model
  import acr_pkg::*;
(
  input wire logic pclk,
  input wire acr_ana_ctrl_t ana_ctrl,
  input wire logic [RESULT_W:0] level,
  output logic comparator_in
);
  // ------------------------------------------------------------------
  // Comparator against the trial code
  // ------------------------------------------------------------------
  // Level may exceed full scale, so the top trial code still compares high
  // A deselected input floats: toggle rather than hold a stale decision
  initial comparator_in = 1'b0;
  always @(posedge pclk) begin
    if (ana_ctrl.mux_en) begin
      comparator_in <= ({1'b0, ana_ctrl.trial} <= level);
    end else begin
      comparator_in <= ~comparator_in;
    end
  end
endmodule // acr_ana_model

// File: verif/adc_control_registers_test.sv
`timescale 1ns/1ns
module adc_control_registers_test;
  import acr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  acr_apb_req_t req = '0;
  logic [RESULT_W:0] level = '0;
  logic comparator_in;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  acr_ana_ctrl_t ana_ctrl;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] rv;
  logic re;

  always #10 pclk = ~pclk;

  acr_top #(.NUM_CHANNELS(12)) acr_top_inst (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .comparator_in(comparator_in), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .ana_ctrl(ana_ctrl));
  acr_ana_model acr_ana_model_inst (.pclk(pclk), .ana_ctrl(ana_ctrl), .level(level),
    .comparator_in(comparator_in));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic results();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One idle edge after release so a following setup never retimes psel in the same step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    re = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    chk("pready", 32'h1, 32'(pready));
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), exp, rv);
  endtask

  task automatic wait_eoc();
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h1c0, 32'h0);
      n++;
    end while (rv[7] !== 1'b1 && n < 100);
    chk("done flag", 32'h1, 32'(rv[7]));
  endtask

  task automatic wait_sample(input logic v);
    int n;
    n = 0;
    while (ana_ctrl.sample !== v && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk("sample level", 32'(v), 32'(ana_ctrl.sample));
  endtask

  // Skips any restart interval so the one measured follows a completed conversion
  task automatic sample_len(input int exp);
    int n;
    wait_sample(1'b1);
    wait_sample(1'b0);
    wait_sample(1'b1);
    n = 0;
    while (ana_ctrl.sample === 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("sample length", 32'(exp), 32'(n));
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rd(12'h1c0, 32'h0);
    rd(12'h1c4, 32'h0);
    rd(12'h1c8, 32'h0);
    rd(12'h1e0, 32'h0);
    chk("unmapped error", 32'h1, 32'(re));
  endtask

  task automatic t_convert();
    apb(1'b1, 12'h1d4, 32'h1);
    level <= 11'h2a5;
    apb(1'b1, 12'h1c0, 32'h22);
    chk("mux_en", 32'h1, 32'(ana_ctrl.mux_en));
    chk("channel", 32'h2, 32'(ana_ctrl.channel));
    rd(12'h1c0, 32'h22);
    wait_eoc();
    chk("irq raised", 32'h1, 32'(irq));
    rd(12'h1cc, 32'h1);
    rd(12'h1c8, 32'h1);
    rd(12'h1c4, 32'ha9);
    rd(12'h1c0, 32'h22);
    apb(1'b1, 12'h1d0, 32'h1);
    chk("irq cleared", 32'h0, 32'(irq));
    apb(1'b1, 12'h1d4, 32'h0);
    wait_eoc();
    chk("irq masked", 32'h0, 32'(irq));
  endtask

  task automatic t_write();
    apb(1'b1, 12'h1c0, 32'hff);
    rd(12'h1c0, 32'h6f);
    chk("mux_en ch15", 32'h0, 32'(ana_ctrl.mux_en));
    apb(1'b1, 12'h1c0, 32'h26);
    chk("mux_en ch6", 32'h0, 32'(ana_ctrl.mux_en));
    chk("channel 6", 32'h6, 32'(ana_ctrl.channel));
  endtask

  task automatic t_speed();
    apb(1'b1, 12'h1c0, 32'h62);
    sample_len(SAMPLE_TICKS * DIV_FAST);
    apb(1'b1, 12'h1c0, 32'h22);
    sample_len(SAMPLE_TICKS * DIV_SLOW);
    // Two slow completions without a high read must have flagged an overrun
    rd(12'h1cc, 32'h3);
  endtask

  task automatic t_sat();
    level <= 11'h44c;
    apb(1'b1, 12'h1c0, 32'h23);
    wait_eoc();
    rd(12'h1c8, 32'h3);
    rd(12'h1c4, 32'hff);
    level <= 11'h000;
    apb(1'b1, 12'h1c0, 32'h22);
    wait_eoc();
    rd(12'h1c8, 32'h0);
    rd(12'h1c4, 32'h0);
  endtask

  task automatic t_change();
    level <= 11'h155;
    repeat (60) @(posedge pclk);
    level <= 11'h3c3;
    apb(1'b1, 12'h1c0, 32'h2a);
    rd(12'h1c0, 32'h2a);
    chk("restart sample", 32'h1, 32'(ana_ctrl.sample));
    chk("mux_en ch10", 32'h1, 32'(ana_ctrl.mux_en));
    wait_eoc();
    rd(12'h1c8, 32'h3);
    rd(12'h1c4, 32'hf0);
  endtask

  task automatic t_off();
    apb(1'b1, 12'h1c0, 32'h0a);
    // Sequencer idles one edge after the stored bit; let that edge pass first
    @(posedge pclk);
    chk("sample off", 32'h0, 32'(ana_ctrl.sample));
    chk("trial off", 32'h0, 32'(ana_ctrl.trial));
    chk("mux_en off", 32'h0, 32'(ana_ctrl.mux_en));
    repeat (300) @(posedge pclk);
    rd(12'h1c0, 32'h0a);
  endtask

  // ------------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_convert();
    t_write();
    t_speed();
    t_sat();
    t_change();
    t_off();
    results();
  end

  initial begin
    #400000;
    miscompares++;
    results();
  end
endmodule // adc_control_registers_test
